// ---- src/bbm_config_bank.v ----
/*
 configuration register bank of a white led backlight driver: adaptive
 boost margin, comparator thresholds, step sizes, spread spectrum,
 settings version and stored switching frequency selection.
 assumes a simple synchronous register port driven by the serial
 front end on the same clock; pin-select straps come from pins.
*/
`include "bbm_map.vh"

module bbm_config_bank
#(
    parameter DITHER_BITS = `BBM_DITHER_BITS
)
(
    input wire i_clk,
    input wire i_reset,
    input wire i_wr_en,
    input wire i_rd_en,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_switch_freq_pin_select,
    input wire i_dimming_freq_pin_select,
    input wire [11:0] i_pin_freq_khz,
    output reg [7:0] o_rdata,
    output reg o_rd_valid,
    output wire o_adaptive_enable,
    output reg [11:0] o_low_thresh_mv,
    output reg [11:0] o_mid_thresh_mv,
    output reg [11:0] o_raise_step_mv,
    output reg [11:0] o_lower_step_mv,
    output reg [11:0] o_switch_freq_khz,
    output reg o_freq_reserved,
    output reg o_use_stored_freq,
    output wire o_spread_clock_enable,
    output reg [DITHER_BITS-1:0] o_dither
);

    reg [7:0] margin_ctrl_reg;
    reg [7:0] margin_step_reg;
    reg [7:0] version_reg;
    reg [7:0] swfreq_reg;
    reg [1:0] sw_pin_sync_reg;
    reg [1:0] dim_pin_sync_reg;
    reg [DITHER_BITS-1:0] lfsr_reg;
    reg [7:0] rdata_next;
    reg [11:0] low_next;
    reg [11:0] hyst_mv;
    reg [11:0] freq_next;
    wire [2:0] margin_sel;
    wire [1:0] freq_code;
    wire use_stored;
    wire [11:0] raise_step_next;
    wire [11:0] lower_step_next;

    assign margin_sel = margin_ctrl_reg[`BBM_MARGIN_SEL_HI:`BBM_MARGIN_SEL_LO];
    assign freq_code = swfreq_reg[`BBM_SWFREQ_HI:`BBM_SWFREQ_LO];
    assign o_adaptive_enable = margin_ctrl_reg[`BBM_TRACK_BIT];
    assign o_spread_clock_enable = margin_ctrl_reg[`BBM_SPREAD_BIT];
    // straps pass two flops before use
    assign use_stored = ~sw_pin_sync_reg[1] & ~dim_pin_sync_reg[1];

    // register writes
    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            margin_ctrl_reg <= `BBM_RST_MARGIN_CTRL;
            margin_step_reg <= `BBM_RST_MARGIN_STEP;
            version_reg <= `BBM_RST_VERSION;
            swfreq_reg <= `BBM_RST_SWFREQ;
        end
        else if (i_wr_en)
        begin
            if (i_addr == `BBM_ADDR_MARGIN_CTRL)
                margin_ctrl_reg <= i_wdata;
            else if (i_addr == `BBM_ADDR_MARGIN_STEP)
                margin_step_reg <= i_wdata;
            else if (i_addr == `BBM_ADDR_VERSION)
                version_reg <= i_wdata;
            else if (i_addr == `BBM_ADDR_SWFREQ)
                swfreq_reg <= i_wdata;
        end
    end

    // read mux
    always @*
    begin
        if (i_addr == `BBM_ADDR_MARGIN_CTRL)
            rdata_next = margin_ctrl_reg;
        else if (i_addr == `BBM_ADDR_MARGIN_STEP)
            rdata_next = margin_step_reg;
        else if (i_addr == `BBM_ADDR_VERSION)
            rdata_next = version_reg;
        else if (i_addr == `BBM_ADDR_SWFREQ)
            rdata_next = swfreq_reg;
        else
            rdata_next = 8'h00;
    end

    // low threshold: top figure less one step per code
    always @*
    begin
        low_next = `BBM_MARGIN_TOP_MV - (`BBM_MARGIN_STEP_MV * {9'h000, margin_sel});
    end

    // mid threshold hysteresis offset
    always @*
    begin
        case (margin_step_reg[`BBM_HYST_HI:`BBM_HYST_LO])
            `BBM_HYST_CODE_1000: hyst_mv = `BBM_HYST_1000_MV;
            `BBM_HYST_CODE_750: hyst_mv = `BBM_HYST_750_MV;
            `BBM_HYST_CODE_500: hyst_mv = `BBM_HYST_500_MV;
            default: hyst_mv = `BBM_HYST_250_MV;
        endcase
    end

    // stored code decode; a strap hands the choice to the pin path
    always @*
    begin
        case (freq_code)
            `BBM_FREQ_312: freq_next = `BBM_KHZ_312;
            `BBM_FREQ_625: freq_next = `BBM_KHZ_625;
            `BBM_FREQ_1250: freq_next = `BBM_KHZ_1250;
            default: freq_next = `BBM_KHZ_312;
        endcase
        if (!use_stored)
            freq_next = i_pin_freq_khz;
    end

    // strap synchronisers
    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            sw_pin_sync_reg <= 2'h0;
            dim_pin_sync_reg <= 2'h0;
        end
        else
        begin
            sw_pin_sync_reg <= {sw_pin_sync_reg[0], i_switch_freq_pin_select};
            dim_pin_sync_reg <= {dim_pin_sync_reg[0], i_dimming_freq_pin_select};
        end
    end

    // read port: data holds until the next read
    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_rdata <= 8'h00;
            o_rd_valid <= 1'b0;
        end
        else
        begin
            o_rd_valid <= i_rd_en;
            if (i_rd_en)
                o_rdata <= rdata_next;
        end
    end

    // thresholds and step sizes, all from flops
    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_low_thresh_mv <= 12'h000;
            o_mid_thresh_mv <= 12'h000;
            o_raise_step_mv <= 12'h000;
            o_lower_step_mv <= 12'h000;
        end
        else
        begin
            o_low_thresh_mv <= low_next;
            o_mid_thresh_mv <= low_next + hyst_mv;
            o_raise_step_mv <= raise_step_next;
            o_lower_step_mv <= lower_step_next;
        end
    end

    // switching frequency selection
    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_switch_freq_khz <= 12'h000;
            o_freq_reserved <= 1'b0;
            o_use_stored_freq <= 1'b0;
        end
        else
        begin
            o_switch_freq_khz <= freq_next;
            o_freq_reserved <= use_stored & (freq_code == `BBM_FREQ_RSVD);
            o_use_stored_freq <= use_stored;
        end
    end

    // dither source runs freely; output gated by the spread bit
    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            lfsr_reg <= {{(DITHER_BITS-1){1'b0}}, 1'b1};
            o_dither <= {DITHER_BITS{1'b0}};
        end
        else
        begin
            lfsr_reg <= {lfsr_reg[DITHER_BITS-2:0],
                lfsr_reg[DITHER_BITS-1] ^ lfsr_reg[DITHER_BITS-2]};
            if (o_spread_clock_enable)
                o_dither <= lfsr_reg;
            else
                o_dither <= {DITHER_BITS{1'b0}};
        end
    end

    bbm_step_decode u_raise
    (
        .i_code(margin_step_reg[`BBM_RAISE_HI:`BBM_RAISE_LO]),
        .o_step_mv(raise_step_next)
    );

    bbm_step_decode u_lower
    (
        .i_code(margin_step_reg[`BBM_LOWER_HI:`BBM_LOWER_LO]),
        .o_step_mv(lower_step_next)
    );

endmodule // bbm_config_bank

// ---- src/bbm_map.vh ----
/*
 register offsets, field positions, reset values and decode codes
 for the backlight boost margin configuration bank.
 assumes inclusion once per compile unit; guarded.
*/
`ifndef BBM_MAP_VH
`define BBM_MAP_VH

`define BBM_ADDR_MARGIN_CTRL 8'haa
`define BBM_ADDR_MARGIN_STEP 8'hae
`define BBM_ADDR_VERSION 8'haf
`define BBM_ADDR_SWFREQ 8'ha6

`define BBM_RST_MARGIN_CTRL 8'h00
`define BBM_RST_MARGIN_STEP 8'h00
`define BBM_RST_VERSION 8'h00
`define BBM_RST_SWFREQ 8'h00

`define BBM_SPREAD_BIT 7
`define BBM_TRACK_BIT 3
`define BBM_MARGIN_SEL_HI 2
`define BBM_MARGIN_SEL_LO 0
`define BBM_RAISE_HI 7
`define BBM_RAISE_LO 6
`define BBM_LOWER_HI 5
`define BBM_LOWER_LO 4
`define BBM_HYST_HI 1
`define BBM_HYST_LO 0
`define BBM_SWFREQ_HI 7
`define BBM_SWFREQ_LO 6

// millivolt figures and hysteresis select codes
`define BBM_MARGIN_TOP_MV 12'h36b
`define BBM_MARGIN_STEP_MV 12'h07d
`define BBM_HYST_1000_MV 12'h3e8
`define BBM_HYST_750_MV 12'h2ee
`define BBM_HYST_500_MV 12'h1f4
`define BBM_HYST_250_MV 12'h0fa
`define BBM_STEP_BASE_MV 12'h069
`define BBM_HYST_CODE_1000 2'h0
`define BBM_HYST_CODE_750 2'h1
`define BBM_HYST_CODE_500 2'h2

// switching frequency codes and values in khz
`define BBM_FREQ_312 2'h0
`define BBM_FREQ_625 2'h1
`define BBM_FREQ_1250 2'h2
`define BBM_FREQ_RSVD 2'h3
`define BBM_KHZ_312 12'h138
`define BBM_KHZ_625 12'h271
`define BBM_KHZ_1250 12'h4e2

`define BBM_DITHER_BITS 4

`endif

// ---- src/bbm_step_decode.v ----
/*
 decodes a 2-bit adaptive step code into millivolts.
 assumes a code from a registered configuration field.
*/
`include "bbm_map.vh"

module bbm_step_decode
(
    input wire [1:0] i_code,
    output wire [11:0] o_step_mv
);

    // 00..11 doubles from the base step
    assign o_step_mv = `BBM_STEP_BASE_MV << i_code;

endmodule // bbm_step_decode

// ---- verification/bbm_config_bank_monitor.sv ----
/* port checker for bbm_config_bank.
 assumes the bind below on every instance. */
module bbm_config_bank_monitor
#(
    parameter DITHER_BITS = 4
)
(
    input wire i_clk,
    input wire i_reset,
    input wire i_wr_en,
    input wire i_rd_en,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire [7:0] o_rdata,
    input wire [11:0] o_low_thresh_mv,
    input wire [11:0] o_mid_thresh_mv,
    input wire [11:0] o_raise_step_mv,
    input wire [11:0] o_lower_step_mv,
    input wire [11:0] o_switch_freq_khz,
    input wire o_use_stored_freq,
    input wire o_adaptive_enable,
    input wire o_spread_clock_enable,
    input wire [DITHER_BITS-1:0] o_dither
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    wire wa = i_wr_en && i_addr == 8'haa;
    wire we = i_wr_en && i_addr == 8'hae;
    ctrl_bits_a: assert property (
        wa |=> {o_spread_clock_enable, o_adaptive_enable} == $past({i_wdata[7], i_wdata[3]}))
        else $error("control bits wrong");
    low_thresh_a: assert property (
        wa |=> ##1 o_low_thresh_mv == 12'h36b - 12'h07d * $past(i_wdata[2:0], 2))
        else $error("low threshold wrong");
    mid_thresh_a: assert property (
        we |=> ##1 o_mid_thresh_mv - o_low_thresh_mv == 12'h3e8 - 12'h0fa * $past(i_wdata[1:0], 2))
        else $error("mid threshold wrong");
    raise_step_a: assert property (
        we |=> ##1 o_raise_step_mv == 12'h069 << $past(i_wdata[7:6], 2))
        else $error("raise step wrong");
    lower_step_a: assert property (
        we |=> ##1 o_lower_step_mv == 12'h069 << $past(i_wdata[5:4], 2))
        else $error("lower step wrong");
    version_rd_a: assert property (
        (i_wr_en && i_addr == 8'haf) ##2 (i_rd_en && i_addr == 8'haf) |=> o_rdata == $past(i_wdata, 3))
        else $error("version readback wrong");
    freq_code_a: assert property (
        (i_wr_en && i_addr == 8'ha6 && o_use_stored_freq) ##2 o_use_stored_freq |->
        o_switch_freq_khz == (($past(i_wdata[7:6], 2) == 2'h1) ? 12'h271 :
        ($past(i_wdata[7:6], 2) == 2'h2) ? 12'h4e2 : 12'h138))
        else $error("stored frequency wrong");
    dither_off_a: assert property (
        !o_spread_clock_enable |=> o_dither == '0) else $error("dither while disabled");
endmodule // bbm_config_bank_monitor

bind bbm_config_bank bbm_config_bank_monitor #(.DITHER_BITS(DITHER_BITS)) bbm_config_bank_monitor_inst (.*);

// ---- verification/bbm_config_bank_tb.sv ----
/* self-checking bench for bbm_config_bank.
 assumes a 100 MHz clock shared by the register port. */
module bbm_config_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_reset = 1, i_wr_en = 0, i_rd_en = 0;
    logic i_switch_freq_pin_select = 0, i_dimming_freq_pin_select = 0;
    logic [7:0] i_addr = 0, i_wdata = 0;
    logic [11:0] i_pin_freq_khz = 0;
    wire [7:0] o_rdata;
    wire o_rd_valid, o_adaptive_enable, o_freq_reserved, o_use_stored_freq, o_spread_clock_enable;
    wire [11:0] o_low_thresh_mv, o_mid_thresh_mv, o_raise_step_mv, o_lower_step_mv;
    wire [11:0] o_switch_freq_khz;
    wire [3:0] o_dither;
    logic [3:0] d;
    logic [7:0] adr [5] = '{8'haa, 8'hae, 8'haf, 8'ha6, 8'h00};
    logic [11:0] khz [4] = '{12'h138, 12'h271, 12'h4e2, 12'h138};
    int err_count = 0, comparisons = 0;
    bbm_config_bank bbm_config_bank_inst (.*);
    always #5 i_clk = ~i_clk;
    task end_sim;
        if (err_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task ck(input string n, input logic [11:0] e, input logic [11:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clk);
        i_wr_en <= 1'h1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr_en <= 1'h0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_rd_en <= 1'h1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd_en <= 1'h0;
        #1;
        ck("rdata", {4'h0, e}, {4'h0, o_rdata});
        ck("rd_valid", 12'h001, {11'h000, o_rd_valid});
    endtask
    task settle;
        repeat (2) @(posedge i_clk);
        #1;
    endtask
    initial
    begin
        repeat (16) @(posedge i_clk);
        i_reset <= 1'h0;
        foreach (adr[k]) rd(adr[k], 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            wr(8'haa, {4'h0, i[0], i[2:0]});
            settle;
            ck("low", 12'h36b - 12'h07d * i[2:0], o_low_thresh_mv);
            ck("track", {11'h000, i[0]}, {11'h000, o_adaptive_enable});
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(8'hae, {i[1:0], ~i[1:0], 2'h0, i[1:0]});
            settle;
            ck("raise", 12'h069 << i[1:0], o_raise_step_mv);
            ck("lower", 12'h069 << (2'h3 - i[1:0]), o_lower_step_mv);
            ck("mid", 12'h3e8 - 12'h0fa * i[1:0], o_mid_thresh_mv - o_low_thresh_mv);
        end
        wr(8'haf, 8'h5c);
        rd(8'haf, 8'h5c);
        wr(8'h00, 8'hff);
        rd(8'haa, 8'h0f);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'ha6, {i[1:0], 6'h00});
            settle;
            ck("freq", khz[i], o_switch_freq_khz);
            ck("rsvd", {11'h000, i == 3}, {11'h000, o_freq_reserved});
        end
        @(posedge i_clk);
        i_pin_freq_khz <= 12'h0ab;
        i_dimming_freq_pin_select <= 1'h1;
        repeat (6) @(posedge i_clk);
        #1;
        ck("pinfreq", 12'h0ab, o_switch_freq_khz);
        @(posedge i_clk);
        i_dimming_freq_pin_select <= 1'h0;
        i_switch_freq_pin_select <= 1'h1;
        repeat (6) @(posedge i_clk);
        #1;
        ck("stored", 12'h000, {11'h000, o_use_stored_freq});
        @(posedge i_clk);
        i_switch_freq_pin_select <= 1'h0;
        repeat (6) @(posedge i_clk);
        #1;
        ck("stored", 12'h001, {11'h000, o_use_stored_freq});
        wr(8'haa, 8'h80);
        repeat (3) @(posedge i_clk);
        #1;
        ck("spread", 12'h001, {11'h000, o_spread_clock_enable});
        d = o_dither;
        @(posedge i_clk);
        #1;
        ck("dither moves", 12'h001, {11'h000, o_dither !== d});
        wr(8'haa, 8'h00);
        settle;
        ck("dither", 12'h000, {8'h00, o_dither});
        end_sim;
    end
    initial
    begin
        #30000;
        err_count++;
        end_sim;
    end
endmodule // bbm_config_bank_tb
